// file: include/readout_pkg.sv
package readout_pkg;
  // Clock and filter timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int FILTER_NS = 620;
  localparam int FILTER_CYC = (FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FILTER_W = 4;
  localparam logic [FILTER_W-1:0] FILTER_LAST = FILTER_W'(FILTER_CYC - 1);
  localparam logic [FILTER_W-1:0] FILTER_ONE = 4'h1;
  // Keyscan row pulse width
  localparam int ROW_PULSE_NS = 39000;
  localparam int ROW_CYC = (ROW_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ROW_W = 10;
  localparam logic [ROW_W-1:0] ROW_LAST = ROW_W'(ROW_CYC - 1);
  localparam logic [ROW_W-1:0] TICK_ONE = 10'h001;
  // Key matrix
  localparam int KEY_ROWS = 5;
  localparam int KEY_BITS = 25;
  localparam logic [KEY_ROWS-1:0] ROW_FIRST = 5'h01;
  localparam logic [KEY_ROWS-1:0] ROW_NONE = 5'h00;
  // Function codes, value is {M2,M1,M0}
  localparam int CODE_W = 3;
  localparam logic [CODE_W-1:0] FC_STOP = 3'h5;
  localparam logic [CODE_W-1:0] FC_SWITCH = 3'h6;
  localparam logic [CODE_W-1:0] FC_ADC = 3'h7;
  localparam logic [1:0] RX_FULL = 2'h3;
  localparam logic [1:0] RX_ONE = 2'h1;
  // Conversion results
  localparam int CHANNELS = 6;
  localparam int RESULT_W = 8;
  localparam int CHAN_W = 3;
  localparam logic [CHAN_W-1:0] CHAN_LIMIT = CHAN_W'(CHANNELS);
  localparam int OUT_BITS = 48;
  localparam int FIFO_W = CHAN_W + RESULT_W;
  localparam int FIFO_DEPTH = 8;
  // Contact counter
  localparam logic [2:0] COUNT_MAX = 3'h7;
  localparam logic [2:0] COUNT_ZERO = 3'h0;
  localparam logic [2:0] COUNT_ONE = 3'h1;
  localparam logic [1:0] STOPS_ONE = 2'h1;
  localparam logic [1:0] STOPS_TWO = 2'h2;
  // Synchronised pin vector positions
  localparam int PIN_CS = 0;
  localparam int PIN_SCLK = 1;
  localparam int PIN_SDI = 2;
  localparam int PIN_A = 3;
  localparam int PIN_N = 5;

  typedef enum logic [2:0] {
    LINK_IDLE = 3'b001,
    LINK_ARMED = 3'b010,
    LINK_SEND = 3'b100
  } link_state_e;

  typedef enum logic [1:0] {
    SCAN_IDLE = 2'b01,
    SCAN_RUN = 2'b10
  } scan_state_e;
endpackage : readout_pkg

// file: include/fifo_if.sv
`timescale 1ns/1ns
interface fifo_if #(parameter int W = 11);
  logic in_valid;
  logic in_ready;
  logic [W-1:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [W-1:0] out_data;
  modport store (input in_valid, output in_ready, input in_data,
                 output out_valid, input out_ready, output out_data);
  modport user (output in_valid, input in_ready, output in_data,
                input out_valid, output out_ready, input out_data);
endinterface : fifo_if

// file: logic/result_fifo.sv
`timescale 1ns/1ns
module result_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst,
  fifo_if.store port
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wptr_ff, nxt_wptr, rptr_ff, nxt_rptr;
  logic [CW-1:0] cnt_ff, nxt_cnt;
  logic in_ready_ff, nxt_in_ready;
  logic out_valid_ff, nxt_out_valid;
  logic [WIDTH-1:0] out_data_ff, nxt_out_data;
  logic push, load;

  assign push = port.in_valid & in_ready_ff;
  assign load = (cnt_ff != '0) & (~out_valid_ff | port.out_ready);
  assign port.in_ready = in_ready_ff;
  assign port.out_valid = out_valid_ff;
  assign port.out_data = out_data_ff;

  // Storage has no reset; only pointers and flags need a defined value
  always_ff @(posedge clk) begin
    if (push) begin
      mem_ff[wptr_ff] <= port.in_data;
    end
  end

  // Read data always leaves through the output register
  always_comb begin
    nxt_wptr = wptr_ff + AW'(push);
    nxt_rptr = rptr_ff + AW'(load);
    nxt_cnt = cnt_ff + CW'(push) - CW'(load);
    nxt_in_ready = nxt_cnt != FULL; // Ready drops as soon as storage fills
    nxt_out_valid = load | (out_valid_ff & ~port.out_ready);
    nxt_out_data = load ? mem_ff[rptr_ff] : out_data_ff;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wptr_ff <= '0;
      rptr_ff <= '0;
      cnt_ff <= '0;
      in_ready_ff <= 1'b0;
      out_valid_ff <= 1'b0;
      out_data_ff <= '0;
    end else begin
      wptr_ff <= nxt_wptr;
      rptr_ff <= nxt_rptr;
      cnt_ff <= nxt_cnt;
      in_ready_ff <= nxt_in_ready;
      out_valid_ff <= nxt_out_valid;
      out_data_ff <= nxt_out_data;
    end
  end
endmodule : result_fifo

// file: logic/encoder_keyscan_adc_readout.sv
`timescale 1ns/1ns
module encoder_keyscan_adc_readout (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic cs_pin,
  input wire logic sclk_pin,
  input wire logic sdata_in,
  output logic sdata_out,
  output logic sdata_oe,
  input wire logic enc_a,
  input wire logic enc_b,
  input wire logic [readout_pkg::KEY_BITS-1:0] key_sense,
  output logic [readout_pkg::KEY_ROWS-1:0] key_row,
  output logic scanning,
  output logic irq,
  output logic up_pulse,
  output logic down_pulse,
  output logic rotation_direction,
  output logic [2:0] contact_count,
  input wire logic adc_valid,
  input wire logic [readout_pkg::CHAN_W-1:0] adc_channel,
  input wire logic [readout_pkg::RESULT_W-1:0] adc_result,
  output logic adc_ready
);
  import readout_pkg::*;

  function automatic logic rise_of(input logic now, input logic was);
    return now & ~was;
  endfunction : rise_of

  // Pin synchronisers and edge history
  logic [PIN_N-1:0] pin_meta_ff, pin_sync_ff, pin_dly_ff;
  logic [KEY_BITS-1:0] key_meta_ff, key_sync_ff, key_last_ff;
  logic cs_rise, cs_fall, sclk_rise, key_change;

  // Link state
  link_state_e link_ff, nxt_link;
  logic [CODE_W-1:0] rx_code_ff, nxt_rx_code;
  logic [1:0] rx_cnt_ff, nxt_rx_cnt;
  logic [OUT_BITS-1:0] shreg_ff, nxt_shreg;
  logic sel_switch_ff, nxt_sel_switch;
  logic oe_ff, nxt_oe, dout_ff, nxt_dout;
  logic frame_ok, cmd_adc, cmd_switch, stop_cmd, clear_event;

  // Encoder, counter, interrupt
  wire [1:0] enc_accept;
  wire [1:0] enc_level;
  logic up_det, down_det;
  logic up_ff, down_ff, dir_ff, nxt_dir, irq_ff, nxt_irq;
  logic [2:0] count_ff, nxt_count, count_base;

  // Keyscan
  scan_state_e scan_ff, nxt_scan;
  logic [KEY_ROWS-1:0] row_ff, nxt_row;
  logic [ROW_W-1:0] tick_ff, nxt_tick;
  logic first_ff, nxt_first;
  logic scan_on_ff, nxt_scan_on;
  logic [1:0] stops_ff, nxt_stops;
  logic scan_first_done;

  // Results
  logic [RESULT_W-1:0] rslt_ff [CHANNELS];
  logic [RESULT_W-1:0] nxt_rslt [CHANNELS];
  logic pop;
  logic [CHAN_W-1:0] pop_chan;

  fifo_if #(.W(FIFO_W)) rq ();

  result_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(sys_clk),
    .rst(rst),
    .port(rq.store)
  );

  // Every link, encoder and key pin crosses two flops before any logic looks at it; the ADC inputs go straight to the FIFO
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pin_meta_ff <= '0;
      pin_sync_ff <= '0;
      pin_dly_ff <= '0;
      key_meta_ff <= '0;
      key_sync_ff <= '0;
      key_last_ff <= '0;
    end else begin
      pin_meta_ff <= {enc_b, enc_a, sdata_in, sclk_pin, cs_pin};
      pin_sync_ff <= pin_meta_ff;
      pin_dly_ff <= pin_sync_ff;
      key_meta_ff <= key_sense;
      key_sync_ff <= key_meta_ff;
      key_last_ff <= key_sync_ff;
    end
  end

  assign cs_rise = rise_of(pin_sync_ff[PIN_CS], pin_dly_ff[PIN_CS]);
  assign cs_fall = rise_of(pin_dly_ff[PIN_CS], pin_sync_ff[PIN_CS]);
  assign sclk_rise = rise_of(pin_sync_ff[PIN_SCLK], pin_dly_ff[PIN_SCLK]);
  assign key_change = |(key_sync_ff ^ key_last_ff);

  assign frame_ok = cs_fall && (link_ff == LINK_IDLE) && (rx_cnt_ff == RX_FULL);
  assign cmd_adc = frame_ok && (rx_code_ff == FC_ADC);
  assign cmd_switch = frame_ok && (rx_code_ff == FC_SWITCH);
  assign stop_cmd = frame_ok && (rx_code_ff == FC_STOP);
  assign clear_event = cmd_switch | (cs_fall & (link_ff == LINK_SEND) & sel_switch_ff);

  // Serial receive and transmit; the last three bits before select falls form the code
  always_comb begin
    nxt_rx_code = rx_code_ff;
    nxt_rx_cnt = rx_cnt_ff;
    nxt_link = link_ff;
    nxt_shreg = shreg_ff;
    nxt_sel_switch = sel_switch_ff;
    if (cs_fall) begin
      nxt_rx_cnt = '0;
    end else if (pin_sync_ff[PIN_CS] && sclk_rise && link_ff == LINK_IDLE) begin
      nxt_rx_code = {pin_sync_ff[PIN_SDI], rx_code_ff[CODE_W-1:1]};
      if (rx_cnt_ff != RX_FULL) begin
        nxt_rx_cnt = rx_cnt_ff + RX_ONE;
      end
    end
    case (link_ff)
      LINK_IDLE: begin
        if (cmd_adc || cmd_switch) begin
          nxt_link = LINK_ARMED;
          nxt_sel_switch = cmd_switch;
          if (cmd_switch) begin
            nxt_shreg = OUT_BITS'({count_ff, dir_ff, key_sync_ff});
          end else begin
            for (int ch = 0; ch < CHANNELS; ch++) begin
              nxt_shreg[ch*RESULT_W +: RESULT_W] = rslt_ff[ch];
            end
          end
        end
      end
      LINK_ARMED: begin
        if (cs_rise) begin
          nxt_link = LINK_SEND;
        end
      end
      LINK_SEND: begin
        if (cs_fall) begin
          nxt_link = LINK_IDLE;
        end else if (sclk_rise) begin
          nxt_shreg = {1'b0, shreg_ff[OUT_BITS-1:1]};
        end
      end
      default: begin
        nxt_link = LINK_IDLE;
      end
    endcase
    nxt_oe = nxt_link == LINK_SEND;
    nxt_dout = nxt_shreg[0];
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      link_ff <= LINK_IDLE;
      rx_code_ff <= '0;
      rx_cnt_ff <= '0;
      shreg_ff <= '0;
      sel_switch_ff <= 1'b0;
      oe_ff <= 1'b0;
      dout_ff <= 1'b0;
    end else begin
      link_ff <= nxt_link;
      rx_code_ff <= nxt_rx_code;
      rx_cnt_ff <= nxt_rx_cnt;
      shreg_ff <= nxt_shreg;
      sel_switch_ff <= nxt_sel_switch;
      oe_ff <= nxt_oe;
      dout_ff <= nxt_dout;
    end
  end

  // system clock
  // A new level is taken only after it has held for the whole filter time
  for (genvar i = 0; i < 2; i++) begin : gen_filt
    logic filt_ff, nxt_filt;
    logic [FILTER_W-1:0] cnt_ff, nxt_cnt;
    assign enc_accept[i] = (pin_sync_ff[PIN_A+i] != filt_ff) && (cnt_ff == FILTER_LAST);
    assign enc_level[i] = filt_ff;
    always_comb begin
      nxt_filt = filt_ff;
      nxt_cnt = '0;
      if (enc_accept[i]) begin
        nxt_filt = pin_sync_ff[PIN_A+i];
      end else if (pin_sync_ff[PIN_A+i] != filt_ff) begin
        nxt_cnt = cnt_ff + FILTER_ONE;
      end
    end
    always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
        filt_ff <= 1'b0;
        cnt_ff <= '0;
      end else begin
        filt_ff <= nxt_filt;
        cnt_ff <= nxt_cnt;
      end
    end
  end

  // Phase decode on the filtered A rise: B low is clockwise, B high the reverse
  assign up_det = enc_accept[0] & pin_sync_ff[PIN_A] & ~enc_level[1];
  assign down_det = enc_accept[0] & pin_sync_ff[PIN_A] & enc_level[1];

  // Counter, direction and interrupt; a set in the clearing cycle survives
  always_comb begin
    count_base = clear_event ? COUNT_ZERO : count_ff;
    nxt_count = count_base;
    nxt_dir = dir_ff;
    if (up_det) begin
      nxt_count = (count_base == COUNT_MAX) ? COUNT_MAX : count_base + COUNT_ONE;
      nxt_dir = 1'b0;
    end else if (down_det) begin
      nxt_count = (count_base == COUNT_ZERO) ? COUNT_ZERO : count_base - COUNT_ONE;
      nxt_dir = 1'b1;
    end
    nxt_irq = irq_ff;
    if (clear_event) begin
      nxt_irq = 1'b0;
    end
    if (up_det || down_det || scan_first_done) begin
      nxt_irq = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      up_ff <= 1'b0;
      down_ff <= 1'b0;
      dir_ff <= 1'b0;
      count_ff <= COUNT_ZERO;
      irq_ff <= 1'b0;
    end else begin
      up_ff <= up_det;
      down_ff <= down_det;
      dir_ff <= nxt_dir;
      count_ff <= nxt_count;
      irq_ff <= nxt_irq;
    end
  end

  assign scan_first_done = (scan_ff == SCAN_RUN) && (tick_ff == ROW_LAST) && row_ff[KEY_ROWS-1] && first_ff;

  // Keyscan sequencer; rows stay quiet while idle to keep scan noise off the board
  always_comb begin
    nxt_scan = scan_ff;
    nxt_row = row_ff;
    nxt_tick = tick_ff;
    nxt_first = first_ff;
    nxt_stops = stops_ff;
    case (scan_ff)
      SCAN_IDLE: begin
        if (key_change) begin
          nxt_scan = SCAN_RUN;
          nxt_row = ROW_FIRST;
          nxt_tick = '0;
          nxt_first = 1'b1;
          nxt_stops = STOPS_ONE;
        end
      end
      SCAN_RUN: begin
        if (tick_ff == ROW_LAST) begin
          nxt_tick = '0;
          nxt_row = {row_ff[KEY_ROWS-2:0], row_ff[KEY_ROWS-1]};
          if (row_ff[KEY_ROWS-1]) begin
            nxt_first = 1'b0;
          end
        end else begin
          nxt_tick = tick_ff + TICK_ONE;
        end
        if (key_change) begin
          nxt_stops = STOPS_TWO;
        end else if (stop_cmd && stops_ff == STOPS_ONE) begin
          nxt_scan = SCAN_IDLE;
          nxt_row = ROW_NONE;
          nxt_tick = '0;
        end else if (stop_cmd) begin
          nxt_stops = STOPS_ONE;
        end
      end
      default: begin
        nxt_scan = SCAN_IDLE;
        nxt_row = ROW_NONE;
      end
    endcase
    // Status pin gets its own flop so it leaves the block glitch free
    nxt_scan_on = nxt_scan == SCAN_RUN;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      scan_ff <= SCAN_IDLE;
      scan_on_ff <= 1'b0;
      row_ff <= ROW_NONE;
      tick_ff <= '0;
      first_ff <= 1'b0;
      stops_ff <= '0;
    end else begin
      scan_ff <= nxt_scan;
      scan_on_ff <= nxt_scan_on;
      row_ff <= nxt_row;
      tick_ff <= nxt_tick;
      first_ff <= nxt_first;
      stops_ff <= nxt_stops;
    end
  end

  // Results drain only while the link is idle, so a word being shifted never changes
  assign rq.in_valid = adc_valid;
  assign rq.in_data = {adc_channel, adc_result};
  assign rq.out_ready = link_ff == LINK_IDLE;
  assign pop = rq.out_valid & rq.out_ready;
  assign pop_chan = rq.out_data[FIFO_W-1 -: CHAN_W];

  always_comb begin
    nxt_rslt = rslt_ff;
    if (pop && pop_chan < CHAN_LIMIT) begin
      nxt_rslt[pop_chan] = rq.out_data[RESULT_W-1:0];
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rslt_ff <= '{default: '0};
    end else begin
      rslt_ff <= nxt_rslt;
    end
  end

  // Outputs
  assign sdata_out = dout_ff;
  assign sdata_oe = oe_ff;
  assign key_row = row_ff;
  assign scanning = scan_on_ff;
  assign irq = irq_ff;
  assign up_pulse = up_ff;
  assign down_pulse = down_ff;
  assign rotation_direction = dir_ff;
  assign contact_count = count_ff;
  assign adc_ready = rq.in_ready;

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  property p_pin_turn;
    link_ff == LINK_ARMED && cs_rise |=> sdata_oe ##0 sdata_out == $past(shreg_ff[0]);
  endproperty
  a_pin_turn: assert property (p_pin_turn) else $error("pin not driven after select rise");
  property p_shift_bit;
    link_ff == LINK_SEND && sclk_rise && !cs_fall |=> sdata_out == $past(shreg_ff[1]);
  endproperty
  a_shift_bit: assert property (p_shift_bit) else $error("wrong bit after clock rise");
  property p_release;
    link_ff == LINK_SEND && cs_fall |=> !sdata_oe [*2];
  endproperty
  a_release: assert property (p_release) else $error("pin still driven after select fall");
  property p_filter;
    $changed(gen_filt[0].filt_ff) |-> $past(gen_filt[0].cnt_ff) == FILTER_LAST;
  endproperty
  a_filter: assert property (p_filter) else $error("encoder level taken too early");
  property p_up_irq;
    up_det |=> up_pulse && irq && !rotation_direction ##1 !up_pulse;
  endproperty
  a_up_irq: assert property (p_up_irq) else $error("up step without pulse or interrupt");
  property p_down_irq;
    down_det |=> down_pulse && irq && rotation_direction;
  endproperty
  a_down_irq: assert property (p_down_irq) else $error("down step without pulse or interrupt");
  property p_count_step;
    up_det && !clear_event && count_ff != COUNT_MAX |=> contact_count == $past(count_ff) + COUNT_ONE;
  endproperty
  a_count_step: assert property (p_count_step) else $error("counter did not count up");
  property p_count_sat;
    up_det && !clear_event && count_ff == COUNT_MAX |=> contact_count == COUNT_MAX;
  endproperty
  a_count_sat: assert property (p_count_sat) else $error("counter wrapped");
  property p_switch_clear;
    cmd_switch && !up_det && !down_det && !scan_first_done |=> !irq && contact_count == COUNT_ZERO;
  endproperty
  a_switch_clear: assert property (p_switch_clear) else $error("switch select did not clear");
  property p_idle_rows;
    !scanning |-> key_row == ROW_NONE;
  endproperty
  a_idle_rows: assert property (p_idle_rows) else $error("rows driven while idle");
  property p_first_irq;
    scan_first_done |=> irq;
  endproperty
  a_first_irq: assert property (p_first_irq) else $error("no interrupt after first scan");
  property p_two_stops;
    scanning && stop_cmd && stops_ff == STOPS_TWO |=> scanning;
  endproperty
  a_two_stops: assert property (p_two_stops) else $error("single stop halted rescan");

  c_adc_read: cover property (cmd_adc ##[1:1000] (link_ff == LINK_SEND));
  c_switch_read: cover property (cmd_switch);
  c_double_stop: cover property (stop_cmd && stops_ff == STOPS_TWO);
  c_saturate: cover property (up_det && count_ff == COUNT_MAX);
endmodule : encoder_keyscan_adc_readout

// file: bench/host_model.sv
`timescale 1ns/1ns
// Host end of the three-wire link; the serial clock only runs inside frames
module host_model (
  input wire logic sys_clk,
  input wire logic sdata_out,
  input wire logic sdata_oe,
  output logic cs_pin,
  output logic sclk_pin,
  output logic sdata_in
);
  logic drv_en = 1'b0;
  logic drv_bit = 1'b0;
  logic last_ff = 1'b0;
  // A released line flips every cycle so a stale bit never looks valid
  assign sdata_in = sdata_oe ? sdata_out : (drv_en ? drv_bit : ~last_ff);
  // Remember the last line level
  always_ff @(posedge sys_clk) begin
    last_ff <= (sdata_in === 1'b1); // An unknown at start must not stick on the idle line
  end
  // Idle link
  initial begin
    cs_pin = 1'b0;
    sclk_pin = 1'b0;
  end
  task tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : tick
  task send(input logic [2:0] code);
    tick(1);
    cs_pin <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      drv_en <= 1'b1;
      drv_bit <= code[i];
      tick(4);
      sclk_pin <= 1'b1;
      tick(4);
      sclk_pin <= 1'b0;
    end
    drv_en <= 1'b0;
    tick(4);
    cs_pin <= 1'b0;
    tick(8);
  endtask : send
  task get(input int n, output logic [47:0] bits, output logic oe);
    bits = '0;
    tick(1);
    cs_pin <= 1'b1;
    tick(8);
    @(negedge sys_clk);
    oe = sdata_oe;
    for (int i = 0; i < n; i++) begin
      bits[i] = sdata_in;
      @(posedge sys_clk);
      sclk_pin <= 1'b1;
      tick(4);
      sclk_pin <= 1'b0;
      tick(3);
      @(negedge sys_clk);
    end
    @(posedge sys_clk);
    cs_pin <= 1'b0;
    tick(8);
  endtask : get
endmodule : host_model

// file: bench/testbench.sv
`timescale 1ns/1ns
module testbench;
  import readout_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic cs_pin, sclk_pin, sdata_in, sdata_out, sdata_oe;
  logic enc_a = 1'b0;
  logic enc_b = 1'b0;
  logic [KEY_BITS-1:0] key_sense = '0;
  logic [KEY_ROWS-1:0] key_row;
  logic scanning, irq, up_pulse, down_pulse, rotation_direction, adc_ready;
  logic [2:0] contact_count;
  logic adc_valid = 1'b0;
  logic [CHAN_W-1:0] adc_channel = '0;
  logic [RESULT_W-1:0] adc_result = '0;
  logic [47:0] got;
  logic oe;
  int fail_count = 0;
  int n_tests = 0;

  // 20 MHz system clock
  initial begin
    forever #25 sys_clk = ~sys_clk;
  end

  encoder_keyscan_adc_readout uut (
    .sys_clk(sys_clk), .rst(rst), .cs_pin(cs_pin), .sclk_pin(sclk_pin),
    .sdata_in(sdata_in), .sdata_out(sdata_out), .sdata_oe(sdata_oe),
    .enc_a(enc_a), .enc_b(enc_b), .key_sense(key_sense), .key_row(key_row),
    .scanning(scanning), .irq(irq), .up_pulse(up_pulse), .down_pulse(down_pulse),
    .rotation_direction(rotation_direction), .contact_count(contact_count),
    .adc_valid(adc_valid), .adc_channel(adc_channel), .adc_result(adc_result),
    .adc_ready(adc_ready)
  );

  host_model host (
    .sys_clk(sys_clk), .sdata_out(sdata_out), .sdata_oe(sdata_oe),
    .cs_pin(cs_pin), .sclk_pin(sclk_pin), .sdata_in(sdata_in)
  );

  task tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : tick

  task check(input logic [47:0] seen, input logic [47:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task results;
    $display("Checks %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : results

  // A wait that used up its bound ends the run
  task lost(input int c, input int lim);
    if (c >= lim) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, c, lim);
      results;
    end
  endtask : lost

  task push(input logic [2:0] ch, input logic [7:0] v, output logic ok);
    @(posedge sys_clk);
    adc_valid <= 1'b1;
    adc_channel <= ch;
    adc_result <= v;
    ok = 1'b0;
    for (int i = 0; i < 4 && !ok; i++) begin
      @(negedge sys_clk);
      ok = (adc_ready === 1'b1);
    end
    @(posedge sys_clk);
    adc_valid <= 1'b0;
  endtask : push

  // Results reach the store, then the FIFO fills while the link holds it
  task t_adc;
    logic ok;
    logic [47:0] e1;
    logic [47:0] e2;
    int n;
    for (int i = 0; i < CHANNELS; i++) begin
      push(3'(i), 8'(17 * i + 17), ok);
      e1[i*8 +: 8] = 8'(17 * i + 17);
    end
    tick(20);
    host.send(FC_ADC);
    n = 0;
    ok = 1'b1;
    for (int i = 0; i < 12 && ok; i++) begin
      push(3'(i % 6), 8'(64 + i), ok);
      if (ok) n++;
      if (ok) e2[(i % 6)*8 +: 8] = 8'(64 + i);
    end
    check(48'(n), 48'd9);
    host.get(48, got, oe);
    check(oe, 1'b1);
    check(got, e1);
    check(sdata_oe, 1'b0);
    tick(40);
    host.send(FC_ADC);
    host.get(48, got, oe);
    check(got, e2);
    $display("adc test done");
  endtask : t_adc

  // Scan starts on a key change and needs two stops after a second change
  task t_scan;
    int c;
    check({scanning, key_row}, 6'h0);
    @(posedge sys_clk);
    key_sense <= 25'h0000021;
    tick(6);
    check(key_row, ROW_FIRST);
    for (c = 0; c < 4200 && irq !== 1'b1; c++) @(negedge sys_clk);
    lost(c, 4200);
    check(c > 3880 && c < 3910, 1'b1);
    @(posedge sys_clk);
    key_sense <= 25'h0000023;
    tick(6);
    host.send(FC_STOP);
    tick(4);
    check(scanning, 1'b1);
    host.send(FC_STOP);
    tick(4);
    check({scanning, key_row}, 6'h0);
    $display("scan test done");
  endtask : t_scan

  task t_switch(input logic [2:0] cnt, input logic dir);
    host.send(FC_SWITCH);
    check({irq, contact_count}, 4'h0);
    host.get(29, got, oe);
    check(oe, 1'b1);
    check(got, {19'h0, cnt, dir, key_sense});
    $display("switch test done");
  endtask : t_switch

  task step(input logic ccw);
    int c;
    @(posedge sys_clk);
    enc_b <= ccw;
    tick(20);
    enc_a <= 1'b1;
    for (c = 0; c < 40 && up_pulse !== 1'b1 && down_pulse !== 1'b1; c++) @(negedge sys_clk);
    lost(c, 40);
    check(c >= 12, 1'b1);
    check({down_pulse, up_pulse, irq}, {ccw, ~ccw, 1'b1});
    @(posedge sys_clk);
    enc_a <= 1'b0;
    tick(20);
    enc_b <= 1'b0;
    tick(20);
  endtask : step

  // Short glitch, saturation, then one step each way
  task t_enc;
    @(posedge sys_clk);
    enc_a <= 1'b1;
    tick(10);
    enc_a <= 1'b0;
    tick(30);
    check({irq, contact_count}, 4'h0);
    for (int i = 0; i < 8; i++) step(1'b0);
    check({rotation_direction, contact_count}, 4'h7);
    step(1'b1);
    check({rotation_direction, contact_count}, 4'he);
    step(1'b0);
    check({rotation_direction, contact_count}, 4'h7);
    tick(100);
    check(irq, 1'b1);
    $display("encoder test done");
  endtask : t_enc

  // State straight after reset release
  task t_reset;
    check({irq, rotation_direction, contact_count, sdata_oe}, 6'h0);
    $display("reset test done");
  endtask : t_reset

  // Main sequence
  initial begin
    tick(16);
    rst <= 1'b0;
    tick(4);
    t_reset;
    t_adc;
    t_scan;
    t_switch(3'h0, 1'b0);
    t_enc;
    t_switch(3'h7, 1'b0);
    results;
  end
endmodule : testbench
